// ---- rtl/tk_seq.sv ----
module tk_seq #(
    parameter int CNT_W = 20  // width of accumulated count
) (
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    // apb slave
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [15:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // analog side
    input  wire logic                     comp_trip,     // reference above threshold
    output tk_seq_pkg::analog_ctl_t       analog_ctl,
    // shared interrupt vector
    input  wire logic                     tk1_irq,       // first controller request
    output logic                          irq_shared
);
    // ==========================================================
    // registers and state
    tk_seq_pkg::cfg_t        cfg_q;       // configuration register
    logic [1:0]              div_q;       // clock divide select
    logic                    ie_q;        // interrupt enable
    logic [1:0]              rpt_q;       // repeat_select
    logic                    flag_q;      // conversion_done_flag
    logic                    busy_q;      // conversion running
    logic [CNT_W-1:0]        count_q;     // latched result
    logic [CNT_W-1:0]        acc_q;       // sum of finished repeats
    logic [CNT_W-1:0]        cyc_q;       // cycles of current repeat
    logic [2:0]              rep_q;       // repeats done
    logic [4:0]              ph_q;        // ticks left in phase
    logic [2:0]              divc_q;      // divider counter
    logic [6:0]              lfsr_q;      // pseudo random source
    tk_seq_pkg::seq_state_t  st_q;        // sequencer state
    logic                    tick;        // system_clock enable
    logic                    wr_en;       // apb write strobe
    logic                    start_wr;    // start command written
    logic                    ph_end;      // phase ends this cycle
    logic                    dump_end;    // charge dump cycle done
    logic                    conv_end;    // one conversion done
    logic                    done;        // all repeats done
    logic [2:0]              rep_last;    // last repeat index
    logic [4:0]              ph_len;      // next phase length
    logic [CNT_W-1:0]        acc_next;    // acc plus this repeat
    logic                    mapped;      // address decodes

    // ==========================================================
    // clock divider
    // divided system_clock as a one cycle enable
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            divc_q <= 3'h0;
        else
            divc_q <= divc_q + 3'h1;
    end

    // full rate or divided by 2, 4, 8
    always_comb
    begin
        unique case (div_q)
            2'd0:    tick = 1'b1;
            2'd1:    tick = divc_q[0];
            2'd2:    tick = &divc_q[1:0];
            default: tick = &divc_q;
        endcase
    end

    // ==========================================================
    // apb slave
    assign wr_en    = psel & penable & pwrite;
    assign pready   = psel & penable;
    assign mapped   = (paddr == tk_seq_pkg::CFG_ADDR) | (paddr == tk_seq_pkg::CMD_ADDR)
                    | (paddr == tk_seq_pkg::COUNT_ADDR) | (paddr == tk_seq_pkg::CLKDIV_ADDR);
    assign pslverr  = psel & penable & ~mapped;
    // start accepted only when enabled and idle
    assign start_wr = wr_en & (paddr == tk_seq_pkg::CMD_ADDR)
                    & pwdata[tk_seq_pkg::CMD_START_BIT] & cfg_q.enable & ~busy_q;

    // read data captured in the setup cycle
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            prdata <= 32'h0000_0000;
        else if (psel & ~penable)
        begin
            unique case (paddr)
                tk_seq_pkg::CFG_ADDR:    prdata <= {24'h00_0000, cfg_q};
                // busy reads at the start position
                tk_seq_pkg::CMD_ADDR:    prdata <= {24'h00_0000, ie_q, 3'h0, rpt_q,
                                                    flag_q, busy_q};
                tk_seq_pkg::COUNT_ADDR:  prdata <= 32'(count_q);
                tk_seq_pkg::CLKDIV_ADDR: prdata <= {30'h0000_0000, div_q};
                default:                 prdata <= 32'h0000_0000;
            endcase
        end
    end

    // configuration and clock divide registers
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfg_q <= tk_seq_pkg::CFG_RESET;
            div_q <= tk_seq_pkg::CLKDIV_RESET;
        end
        else if (wr_en)
        begin
            if (paddr == tk_seq_pkg::CFG_ADDR)
                cfg_q <= pwdata[7:0];
            if (paddr == tk_seq_pkg::CLKDIV_ADDR)
                div_q <= pwdata[1:0];
        end
    end

    // command register fields
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            ie_q  <= 1'b0;
            rpt_q <= 2'h0;
        end
        else if (wr_en && paddr == tk_seq_pkg::CMD_ADDR)
        begin
            ie_q <= pwdata[tk_seq_pkg::CMD_IE_BIT];
            // repeat count frozen while running
            if (!busy_q)
                rpt_q <= pwdata[tk_seq_pkg::CMD_RPT_LSB +: 2];
        end
    end

    // done flag: writing 0 clears, completion wins
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            flag_q <= 1'b0;
        else if (done)
            flag_q <= 1'b1;
        else if (wr_en && paddr == tk_seq_pkg::CMD_ADDR && !pwdata[tk_seq_pkg::CMD_FLAG_BIT])
            flag_q <= 1'b0;
    end

    // ==========================================================
    // sequencer
    assign ph_end   = tick & (ph_q == 5'h0);
    assign dump_end = (st_q == tk_seq_pkg::ST_DUMP) & ph_end;
    // trip sampled when a dump completes
    assign conv_end = dump_end & comp_trip;
    // 1, 2, 4 or 8 repeats
    assign rep_last = 3'((4'h1 << rpt_q) - 4'h1);
    assign done     = conv_end & (rep_q == rep_last);
    assign acc_next = acc_q + cyc_q + CNT_W'(1);
    // phase length is charge_dump_time plus one ticks
    // pseudo random mode stretches a phase by one tick
    assign ph_len   = {1'b0, cfg_q.cd_time} + 5'((cfg_q.pseudo_rand & lfsr_q[0]));

    // pseudo random source, steps each phase
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            lfsr_q <= tk_seq_pkg::LFSR_SEED;
        else if (ph_end)
            lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
    end

    // state machine and phase timer
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            st_q <= tk_seq_pkg::ST_IDLE;
            ph_q <= 5'h0;
        end
        else if (!cfg_q.enable)
            // disabling aborts any run
            st_q <= tk_seq_pkg::ST_IDLE;
        else
        begin
            unique case (st_q)
                tk_seq_pkg::ST_IDLE:
                    if (start_wr)
                    begin
                        // begin by zeroing the reference
                        st_q <= tk_seq_pkg::ST_ZERO;
                        ph_q <= 5'(tk_seq_pkg::ZERO_TICKS - 1);
                    end
                tk_seq_pkg::ST_ZERO:
                    if (ph_end)
                    begin
                        // release ground switch, start transfers
                        st_q <= tk_seq_pkg::ST_CHARGE;
                        ph_q <= ph_len;
                    end
                    else if (tick)
                        ph_q <= ph_q - 5'h1;
                tk_seq_pkg::ST_CHARGE:
                    if (ph_end)
                    begin
                        // charge then dump
                        st_q <= tk_seq_pkg::ST_DUMP;
                        ph_q <= ph_len;
                    end
                    else if (tick)
                        ph_q <= ph_q - 5'h1;
                tk_seq_pkg::ST_DUMP:
                    if (done)
                        st_q <= tk_seq_pkg::ST_IDLE;
                    else if (conv_end)
                    begin
                        // next repeat re-zeroes the reference
                        st_q <= tk_seq_pkg::ST_ZERO;
                        ph_q <= 5'(tk_seq_pkg::ZERO_TICKS - 1);
                    end
                    else if (ph_end)
                    begin
                        // another cycle
                        st_q <= tk_seq_pkg::ST_CHARGE;
                        ph_q <= ph_len;
                    end
                    else if (tick)
                        ph_q <= ph_q - 5'h1;
            endcase
        end
    end

    // busy follows the run; start self clears at end
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            busy_q <= 1'b0;
        else if (start_wr)
            busy_q <= 1'b1;
        else if (done || !cfg_q.enable)
            busy_q <= 1'b0;
    end

    // cycle counter and repeat accumulation
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            cyc_q <= '0;
            acc_q <= '0;
            rep_q <= 3'h0;
        end
        else if (start_wr)
        begin
            cyc_q <= '0;
            acc_q <= '0;
            rep_q <= 3'h0;
        end
        else if (conv_end)
        begin
            cyc_q <= '0;
            acc_q <= acc_next;
            rep_q <= rep_q + 3'h1;
        end
        else if (dump_end)
            cyc_q <= cyc_q + CNT_W'(1);
    end

    // result latched at completion
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            count_q <= '0;
        else if (done)
            count_q <= acc_next;
    end

    // ==========================================================
    // outputs
    // switch controls decoded from state
    always_comb
    begin
        analog_ctl.ref_discharge = (st_q == tk_seq_pkg::ST_ZERO);
        analog_ctl.charge        = (st_q == tk_seq_pkg::ST_CHARGE);
        analog_ctl.dump          = (st_q == tk_seq_pkg::ST_DUMP);
        analog_ctl.ref_source    = cfg_q.ref_source;
        analog_ctl.threshold     = cfg_q.threshold;
    end

    // completion request merged onto the shared vector
    assign irq_shared = (flag_q & ie_q) | tk1_irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    logic [4:0] chk_ticks;  // ticks seen in charge phase
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
            chk_ticks <= 5'h0;
        else if (!analog_ctl.charge)
            chk_ticks <= 5'h0;
        else if (tick)
            chk_ticks <= chk_ticks + 5'h1;
    end

    logic [3:0] chk_zeros;   // zeroing phases since start
    logic       chk_disc_q;  // ground switch one cycle back
    // counts each zeroing entry, one per repeat
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            chk_zeros  <= 4'h0;
            chk_disc_q <= 1'b0;
        end
        else
        begin
            chk_disc_q <= analog_ctl.ref_discharge;
            if (start_wr)
                chk_zeros <= 4'h0;
            else if (analog_ctl.ref_discharge && !chk_disc_q)
                chk_zeros <= chk_zeros + 4'h1;
        end
    end

    a_start_needs_cmd: assert property ($rose(busy_q) |-> $past(start_wr))
        else $error("busy without start command");
    a_zero_first: assert property (
        $rose(busy_q) |-> analog_ctl.ref_discharge && !analog_ctl.charge)
        else $error("reference not zeroed first");
    a_charge_len: assert property (
        $fell(analog_ctl.charge) && !$past(cfg_q.pseudo_rand) && $past(cfg_q.enable)
        |-> chk_ticks == 5'($past(cfg_q.cd_time)) + 5'h1)
        else $error("charge phase length wrong");
    a_cycle_count: assert property (
        dump_end && !conv_end && !start_wr |=> cyc_q == $past(cyc_q) + CNT_W'(1))
        else $error("cycle not counted");
    a_count_latch: assert property (done |=> count_q == $past(acc_next))
        else $error("count not latched");
    a_done_flag: assert property (done |=> flag_q && !busy_q)
        else $error("completion not flagged");
    a_irq_shared: assert property (flag_q && ie_q |-> irq_shared)
        else $error("interrupt not raised");
    a_enable_gate: assert property (!cfg_q.enable |=> !busy_q && !analog_ctl.charge)
        else $error("runs while disabled");
    a_repeat_sum: assert property (done |-> chk_zeros == (4'h1 << rpt_q))
        else $error("repeat count wrong");
    a_flag_held: assert property (
        flag_q && !(wr_en && paddr == tk_seq_pkg::CMD_ADDR) |=> flag_q)
        else $error("flag dropped without clear");
endmodule : tk_seq

// ---- rtl/tk_seq_pkg.sv ----
package tk_seq_pkg;
    // ==========================================================
    // register byte addresses on the apb bus
    localparam logic [15:0] CFG_ADDR   = 16'ha008;
    localparam logic [15:0] CMD_ADDR   = 16'ha00c;
    localparam logic [15:0] COUNT_ADDR = 16'ha010;
    localparam logic [15:0] CLKDIV_ADDR = 16'ha014;
    // ==========================================================
    // reset values
    localparam logic [7:0]  CFG_RESET    = 8'h00;
    localparam logic [1:0]  CLKDIV_RESET = 2'h0;
    // ==========================================================
    // field positions
    localparam int CFG_EN_BIT    = 7;   // controller_enable_bit
    localparam int CMD_IE_BIT    = 7;   // completion interrupt enable
    localparam int CMD_RPT_LSB   = 2;   // repeat_select
    localparam int CMD_FLAG_BIT  = 1;   // conversion_done_flag
    localparam int CMD_START_BIT = 0;   // start on write, busy on read
    // ==========================================================
    // timing: reference zeroing length in system_clock ticks
    localparam int ZERO_TICKS = 16;
    // pseudo random lfsr seed
    localparam logic [6:0] LFSR_SEED = 7'h5a;

    // configuration fields, bit 7 down to bit 0
    typedef struct packed {
        logic       enable;       // controller_enable_bit
        logic       pseudo_rand;  // pseudo_random_enable
        logic       ref_source;   // reference_source_select
        logic       threshold;    // threshold_select
        logic [3:0] cd_time;      // charge_dump_time
    } cfg_t;

    // analog switch and select controls
    typedef struct packed {
        logic ref_discharge;  // reference_capacitor switch to ground
        logic charge;         // sense_capacitor to reference voltage
        logic dump;           // sense_capacitor onto reference_capacitor
        logic ref_source;     // 0 core_supply, 1 main supply
        logic threshold;      // 0 three quarters, 1 one half
    } analog_ctl_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ZERO,
        ST_CHARGE,
        ST_DUMP
    } seq_state_t;
endpackage : tk_seq_pkg

// ---- sim/key_cap_model.sv ----
// ==========================================================
// sense and reference capacitor pair seen through the comparator
module key_cap_model
(
    input  wire logic                    mclk,
    input  wire logic                    resetn,
    input  wire tk_seq_pkg::analog_ctl_t analog_ctl,  // switch controls
    input  wire logic [3:0]              dumps_full,  // dumps to reach three quarters
    input  wire logic [3:0]              dumps_half,  // dumps to reach one half
    output logic                         comp_trip    // reference above threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] dumps_q;  // finished dumps since zeroing
    logic       dump_q;   // dump level one cycle back
    logic [3:0] need;     // dumps needed for the chosen threshold
    // ==========================================================
    // charge on the reference cap kept as a dump count
    always_ff @(posedge mclk or negedge resetn)
    begin
        if (!resetn)
        begin
            dumps_q <= 4'h0;
            dump_q  <= 1'b0;
        end
        else
        begin
            dump_q <= analog_ctl.dump;
            if (analog_ctl.ref_discharge)  // shorted to ground empties it
                dumps_q <= 4'h0;
            else if (dump_q && !analog_ctl.dump)  // one charge moved over
                dumps_q <= dumps_q + 4'h1;
        end
    end
    // lower threshold is crossed after fewer dumps
    assign need      = analog_ctl.threshold ? dumps_half : dumps_full;
    // comparator stays high once charged, until the next zeroing
    assign comp_trip = (dumps_q >= need) || (analog_ctl.dump && dumps_q == need - 4'h1);
endmodule : key_cap_model

// ---- sim/switched_cap_touch_key_sequencer_test.sv ----
module switched_cap_touch_key_sequencer_test;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic        mclk, resetn, psel, penable, pwrite, tk1_irq;  // bench driven
    logic        pready, pslverr, comp_trip, irq_shared, err;   // observed
    logic [15:0] paddr;                                         // apb byte address
    logic [31:0] pwdata, prdata, rd;                            // apb data
    logic [3:0]  dumps_full, dumps_half;                        // model trip points
    tk_seq_pkg::analog_ctl_t analog_ctl;                        // switch controls
    int          num_errors, n_checks, seed, zero_run, chg_run, zero_len, chg_len;

    tk_seq u_tk_seq (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .comp_trip(comp_trip),
        .analog_ctl(analog_ctl), .tk1_irq(tk1_irq), .irq_shared(irq_shared));
    key_cap_model u_key_cap_model (.mclk(mclk), .resetn(resetn), .analog_ctl(analog_ctl),
        .dumps_full(dumps_full), .dumps_half(dumps_half), .comp_trip(comp_trip));

    // ==========================================================
    // clock, hang guard and phase length monitor
    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        $display("[ERR] run time expected below limit seen limit");
        tally_and_finish();
    end
    always @(posedge mclk)
    begin
        zero_run <= analog_ctl.ref_discharge ? zero_run + 1 : 0;
        chg_run  <= analog_ctl.charge ? chg_run + 1 : 0;
        if (!analog_ctl.ref_discharge && zero_run != 0) zero_len <= zero_run;
        if (!analog_ctl.charge && chg_run != 0) chg_len <= chg_run;
    end

    // ==========================================================
    // bus cycles, comparison and closing
    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wait_idle();
        int k = 0;
        do
        begin
            apb(1'b0, tk_seq_pkg::CMD_ADDR, 32'h0000_0000);
            k++;
        end
        while (rd[0] !== 1'b0 && k < 8000);
    endtask : wait_idle
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    // summed count over all repeats
    function automatic logic [31:0] exp_count(input logic [1:0] rpt, input logic [3:0] tgt);
        return {28'h000_0000, tgt} << rpt;
    endfunction : exp_count

    // ==========================================================
    // main sequence
    initial
    begin
        logic [31:0] r;
        logic [7:0]  cfg;
        logic [1:0]  div, rpt;
        logic        ie;
        {psel, penable, pwrite, tk1_irq, resetn} = 5'h00;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        dumps_full = 4'h3;
        dumps_half = 4'h2;
        seed = 79116;
        repeat (20) @(posedge mclk);
        resetn <= 1'b1;
        apb(1'b0, tk_seq_pkg::CFG_ADDR, 32'h0000_0000);
        chk("cfg reset", {24'h00_0000, tk_seq_pkg::CFG_RESET}, rd);
        apb(1'b0, 16'ha0f0, 32'h0000_0000);
        chk("unmapped error", 32'h0000_0001, {31'h0, err});
        chk("unmapped data", 32'h0000_0000, rd);
        apb(1'b1, tk_seq_pkg::CMD_ADDR, 32'h0000_0001);
        apb(1'b0, tk_seq_pkg::CMD_ADDR, 32'h0000_0000);
        chk("start while off", 32'h0000_0000, {31'h0, rd[0]});
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            div = r[9:8];
            rpt = (i == 1) ? 2'b11 : r[11:10];
            ie = r[12];
            cfg = {1'b1, r[6:4], (i == 0) ? 4'hf : r[3:0]};
            dumps_full <= 4'h1 + {2'b00, r[14:13]};
            dumps_half <= 4'h1 + {3'b000, r[15]};
            apb(1'b1, tk_seq_pkg::CLKDIV_ADDR, {30'h0, div});
            apb(1'b1, tk_seq_pkg::CFG_ADDR, {24'h00_0000, cfg});
            apb(1'b0, tk_seq_pkg::CFG_ADDR, 32'h0000_0000);
            chk("cfg readback", {24'h00_0000, cfg}, rd);
            chk("ref source", {31'h0, cfg[5]}, {31'h0, analog_ctl.ref_source});
            chk("threshold", {31'h0, cfg[4]}, {31'h0, analog_ctl.threshold});
            apb(1'b1, tk_seq_pkg::CMD_ADDR, {24'h00_0000, ie, 3'h0, rpt, 2'b01});
            apb(1'b0, tk_seq_pkg::CMD_ADDR, 32'h0000_0000);
            chk("busy", 32'h0000_0001, {31'h0, rd[0]});
            wait_idle();
            apb(1'b0, tk_seq_pkg::COUNT_ADDR, 32'h0000_0000);
            chk("count", exp_count(rpt, cfg[4] ? dumps_half : dumps_full), rd);
            apb(1'b0, tk_seq_pkg::CMD_ADDR, 32'h0000_0000);
            chk("done flag", 32'h0000_0001, {31'h0, rd[1]});
            chk("irq", {31'h0, ie}, {31'h0, irq_shared});
            if (!cfg[6])
                chk("charge length", {28'h0, cfg[3:0]} + 1 << div, chg_len);
            if (div == 2'b00)
                chk("zero length", tk_seq_pkg::ZERO_TICKS, zero_len);
            apb(1'b1, tk_seq_pkg::CMD_ADDR, {24'h00_0000, ie, 3'h0, rpt, 2'b00});
            @(posedge mclk);
            chk("irq cleared", 32'h0000_0000, {31'h0, irq_shared});
            tk1_irq <= 1'b1;
            @(posedge mclk);
            chk("shared vector", 32'h0000_0001, {31'h0, irq_shared});
            tk1_irq <= 1'b0;
            apb(1'b0, tk_seq_pkg::CMD_ADDR, 32'h0000_0000);
            chk("flag cleared", 32'h0000_0000, {31'h0, rd[1]});
        end
        apb(1'b1, tk_seq_pkg::CFG_ADDR, 32'h0000_008f);
        apb(1'b1, tk_seq_pkg::CMD_ADDR, 32'h0000_0001);
        apb(1'b1, tk_seq_pkg::CFG_ADDR, 32'h0000_0000);
        apb(1'b0, tk_seq_pkg::CMD_ADDR, 32'h0000_0000);
        chk("abort busy and flag", 32'h0000_0000, {30'h0, rd[1:0]});
        tally_and_finish();
    end
endmodule : switched_cap_touch_key_sequencer_test
